// ==== hw/tca_pkg.sv ====
// shared constants for the timer count access block
package tca_pkg;

    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_CTRL       = 8'h00;  // enable, mode, input polarity
    localparam logic [7:0] ADDR_COUNT_HI   = 8'h04;  // count_upper_byte
    localparam logic [7:0] ADDR_COUNT_LO   = 8'h08;  // count_lower_byte / count_lower_byte_read
    localparam logic [7:0] ADDR_RELOAD     = 8'h0C;  // 16-bit reload value
    localparam logic [7:0] ADDR_CAPTURE    = 8'h10;  // 16-bit captured count, read only
    localparam logic [7:0] ADDR_STATUS     = 8'h14;  // sticky events, write one to clear
    localparam logic [7:0] ADDR_MASK       = 8'h18;  // interrupt mask, same layout as status

    // control field positions
    localparam int CTRL_EN_BIT  = 0;                 // timer enable
    localparam int CTRL_MODE_LO = 1;                 // mode field low bit
    localparam int CTRL_MODE_HI = 2;                 // mode field high bit
    localparam int CTRL_POL_BIT = 3;                 // 0 rising edge, 1 falling edge

    // status and mask field positions
    localparam int STAT_RELOAD_BIT  = 0;             // counter reloaded
    localparam int STAT_CAPTURE_BIT = 1;             // input edge captured the count
    localparam int STAT_W           = 2;             // width of status and mask

    // reset values
    localparam logic [15:0] RESET_COUNT  = 16'h0000;
    localparam logic [15:0] RESET_RELOAD = 16'hFFFF;
    localparam logic [15:0] RESET_CAPT   = 16'h0000;
    localparam logic [7:0]  RESET_HOLD   = 8'h00;
    localparam logic [3:0]  RESET_CTRL   = 4'h0;

    // counting modes
    typedef enum logic [1:0] {
        TCA_MODE_CONT,                               // count every clock, reload on match
        TCA_MODE_COUNTER,                            // count qualifying input edges
        TCA_MODE_CAPTURE,                            // count clocks, input edge captures
        TCA_MODE_SPARE                               // behaves as continuous
    } tca_mode_t;

endpackage

// ==== hw/tca_edge_if.sv ====
// carries edge polarity to the detector and the edge pulse back
interface tca_edge_if;
    logic falling;                                   // select falling edge when high
    logic edge_seen;                                 // one-cycle qualifying edge pulse

    modport det (input falling, output edge_seen);
    modport use_side (output falling, input edge_seen);
endinterface

// ==== hw/tca_edge.sv ====
// qualifying edge detector for the timer input pin
module tca_edge (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pin_in,
    tca_edge_if.det   eif
);
    logic prev_ff;                                   // pin level one clock ago

    // pin is synchronous to clock, so one stage of history is enough
    always_ff @(posedge clock) begin
        if (rst) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= pin_in;
        end
    end

    // pick the edge direction that software selected
    assign eif.edge_seen = eif.falling ? (prev_ff & ~pin_in) : (~prev_ff & pin_in);

endmodule // tca_edge

// ==== hw/tca_timer.sv ====
// Overview of operation
// - input mode starts counting on first edge
// - starting edge raises no interrupt
// - count readable as upper and lower bytes
// - count reads never disturb timer operation
// - enabled upper read copies lower into hold
// - enabled lower read returns hold register
// - disabled lower read returns live byte
// - byte writes land separately, never atomic
// - output pin toggles on every reload
// - capture value minus start gives elapsed clocks
//
// The register addresses and register access over APB were chosen for this implementation.
module tca_timer (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        timer_in,
    output logic             timer_out,
    output logic             irq
);
    localparam int STAT_W_L = tca_pkg::STAT_W;       // status and mask width, needed by the declarations below
    logic [3:0]           ctrl_ff;                   // enable, mode, polarity
    logic [15:0]          count_ff;                  // live counter
    logic [15:0]          reload_ff;                 // match value
    logic [15:0]          capt_ff;                   // captured count
    logic [7:0]           hold_ff;                   // lower byte snapshot
    logic                 started_ff;                // counting has begun
    logic [STAT_W_L-1:0]  stat_ff;                   // sticky events
    logic [STAT_W_L-1:0]  mask_ff;                   // interrupt enables
    logic                 pready_ff;                 // access answer
    logic [31:0]          prdata_ff;                 // read data
    logic                 pslverr_ff;                // unmapped address
    logic                 tout_ff;                   // timer output level
    logic                 irq_ff;                    // interrupt level

    tca_edge_if eif ();                              // link to the edge detector

    tca_edge u_edge (
        .clock  (clock),
        .rst    (rst),
        .pin_in (timer_in),
        .eif    (eif)
    );

    // decoded control fields
    logic              enabled;                      // timer running
    tca_pkg::tca_mode_t mode;                        // selected mode
    assign enabled     = ctrl_ff[tca_pkg::CTRL_EN_BIT];
    assign mode        = tca_pkg::tca_mode_t'(ctrl_ff[tca_pkg::CTRL_MODE_HI:tca_pkg::CTRL_MODE_LO]);
    assign eif.falling = ctrl_ff[tca_pkg::CTRL_POL_BIT];

    // apb access: answered one cycle into the access phase
    logic take;                                      // access accepted this edge
    logic wr;                                        // accepted write
    logic rd;                                        // accepted read
    logic mapped;                                    // address hits a register
    assign take = psel & penable & ~pready_ff;
    assign wr   = take & pwrite;
    assign rd   = take & ~pwrite;
    always_comb begin
        case (paddr)
            tca_pkg::ADDR_CTRL, tca_pkg::ADDR_COUNT_HI, tca_pkg::ADDR_COUNT_LO,
            tca_pkg::ADDR_RELOAD, tca_pkg::ADDR_CAPTURE, tca_pkg::ADDR_STATUS,
            tca_pkg::ADDR_MASK: mapped = 1'b1;
            default:            mapped = 1'b0;
        endcase
    end

    // counting events
    logic edge_q;                                    // qualifying input edge
    logic first_edge;                                // starting edge of input mode
    logic inc_evt;                                   // counter advances this edge
    logic reload_evt;                                // counter wraps to one
    logic capt_evt;                                  // capture taken
    assign edge_q     = eif.edge_seen;
    assign first_edge = enabled & ~started_ff & (mode == tca_pkg::TCA_MODE_COUNTER) & edge_q;
    // counter mode advances only on edges; other modes on every clock
    assign inc_evt    = enabled & started_ff & ((mode == tca_pkg::TCA_MODE_COUNTER) ? edge_q : 1'b1);
    assign reload_evt = inc_evt & (count_ff == reload_ff);
    assign capt_evt   = enabled & started_ff & (mode == tca_pkg::TCA_MODE_CAPTURE) & edge_q;

    // bus handshake and read data
    always_ff @(posedge clock) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= take;
            pslverr_ff <= take & ~mapped;
            if (rd) begin
                case (paddr)
                    tca_pkg::ADDR_CTRL:     prdata_ff <= {28'h000_0000, ctrl_ff};
                    tca_pkg::ADDR_COUNT_HI: prdata_ff <= {24'h00_0000, count_ff[15:8]};
                    tca_pkg::ADDR_COUNT_LO: begin
                        // enabled reads see the snapshot, disabled see the counter
                        if (enabled) begin
                            prdata_ff <= {24'h00_0000, hold_ff};
                        end else begin
                            prdata_ff <= {24'h00_0000, count_ff[7:0]};
                        end
                    end
                    tca_pkg::ADDR_RELOAD:   prdata_ff <= {16'h0000, reload_ff};
                    tca_pkg::ADDR_CAPTURE:  prdata_ff <= {16'h0000, capt_ff};
                    tca_pkg::ADDR_STATUS:   prdata_ff <= {30'h0000_0000, stat_ff};
                    tca_pkg::ADDR_MASK:     prdata_ff <= {30'h0000_0000, mask_ff};
                    default:                prdata_ff <= 32'h0000_0000;
                endcase
            end else if (take) begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    // control, reload and mask registers
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff   <= tca_pkg::RESET_CTRL;
            reload_ff <= tca_pkg::RESET_RELOAD;
            mask_ff   <= '0;
        end else if (wr) begin
            case (paddr)
                tca_pkg::ADDR_CTRL:   ctrl_ff   <= pwdata[3:0];
                tca_pkg::ADDR_RELOAD: reload_ff <= pwdata[15:0];
                tca_pkg::ADDR_MASK:   mask_ff   <= pwdata[STAT_W_L-1:0];
                default:              ctrl_ff   <= ctrl_ff;
            endcase
        end
    end

    // start gate: input mode waits for its first edge, others start at once
    always_ff @(posedge clock) begin
        if (rst) begin
            started_ff <= 1'b0;
        end else if (!enabled) begin
            started_ff <= 1'b0;
        end else if (mode != tca_pkg::TCA_MODE_COUNTER) begin
            started_ff <= 1'b1;
        end else if (first_edge) begin
            started_ff <= 1'b1;
        end
    end

    // counter: byte writes win over counting; reads never touch it
    // no write staging exists, so a two-byte update is two separate events
    always_ff @(posedge clock) begin
        if (rst) begin
            count_ff <= tca_pkg::RESET_COUNT;
        end else if (wr && paddr == tca_pkg::ADDR_COUNT_HI) begin
            count_ff[15:8] <= pwdata[7:0];
        end else if (wr && paddr == tca_pkg::ADDR_COUNT_LO) begin
            count_ff[7:0] <= pwdata[7:0];
        end else if (reload_evt) begin
            count_ff <= 16'h0001;
        end else if (inc_evt) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    // lower byte snapshot, taken only on an enabled upper read
    always_ff @(posedge clock) begin
        if (rst) begin
            hold_ff <= tca_pkg::RESET_HOLD;
        end else if (rd && enabled && paddr == tca_pkg::ADDR_COUNT_HI) begin
            hold_ff <= count_ff[7:0];
        end
    end

    // capture keeps the raw count; elapsed clocks = capture minus start
    always_ff @(posedge clock) begin
        if (rst) begin
            capt_ff <= tca_pkg::RESET_CAPT;
        end else if (capt_evt) begin
            capt_ff <= count_ff;
        end
    end

    // output pin toggles on each reload
    always_ff @(posedge clock) begin
        if (rst) begin
            tout_ff <= 1'b0;
        end else if (reload_evt) begin
            tout_ff <= ~tout_ff;
        end
    end

    // sticky status: a set in the clearing cycle wins over the clear
    // the starting edge is deliberately not an event
    logic [STAT_W_L-1:0] set_vec;                    // events this cycle
    logic [STAT_W_L-1:0] clr_vec;                    // write-one-to-clear bits
    always_comb begin
        set_vec = '0;
        set_vec[tca_pkg::STAT_RELOAD_BIT]  = reload_evt;
        set_vec[tca_pkg::STAT_CAPTURE_BIT] = capt_evt;
        clr_vec = (wr && paddr == tca_pkg::ADDR_STATUS) ? pwdata[STAT_W_L-1:0] : '0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~clr_vec) | set_vec;
        end
    end

    // interrupt level follows unmasked status at the same edge; a mask write shows one clock later
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(((stat_ff & ~clr_vec) | set_vec) & mask_ff);
        end
    end

    assign pready    = pready_ff;
    assign prdata    = prdata_ff;
    assign pslverr   = pslverr_ff;
    assign timer_out = tout_ff;
    assign irq       = irq_ff;

    // checks on the count access and output behaviour
    a_first_edge_hold: assert property (@(posedge clock) disable iff (rst)
        first_edge && !wr |=> started_ff && $stable(count_ff))
        else $error("starting edge changed the count");

    a_first_no_irq: assert property (@(posedge clock) disable iff (rst)
        first_edge && !wr |=> stat_ff == $past(stat_ff))
        else $error("starting edge set a status bit");

    a_upper_read: assert property (@(posedge clock) disable iff (rst)
        rd && paddr == tca_pkg::ADDR_COUNT_HI |=> prdata_ff[7:0] == $past(count_ff[15:8]))
        else $error("upper byte read wrong");

    a_read_no_effect: assert property (@(posedge clock) disable iff (rst)
        rd && inc_evt && !reload_evt |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("read disturbed counting");

    a_hold_snap: assert property (@(posedge clock) disable iff (rst)
        rd && enabled && paddr == tca_pkg::ADDR_COUNT_HI |=> hold_ff == $past(count_ff[7:0]))
        else $error("hold not loaded on upper read");

    a_lower_hold: assert property (@(posedge clock) disable iff (rst)
        rd && enabled && paddr == tca_pkg::ADDR_COUNT_LO |=> prdata_ff[7:0] == $past(hold_ff))
        else $error("enabled lower read not from hold");

    a_lower_live: assert property (@(posedge clock) disable iff (rst)
        rd && !enabled && paddr == tca_pkg::ADDR_COUNT_LO |=> prdata_ff[7:0] == $past(count_ff[7:0]))
        else $error("disabled lower read not live");

    a_byte_write: assert property (@(posedge clock) disable iff (rst)
        wr && paddr == tca_pkg::ADDR_COUNT_HI
        |=> count_ff[15:8] == $past(pwdata[7:0]) && count_ff[7:0] == $past(count_ff[7:0]))
        else $error("upper write touched lower byte");

    a_out_toggle: assert property (@(posedge clock) disable iff (rst)
        reload_evt |=> timer_out != $past(tout_ff) ##1 1'b1)
        else $error("output did not toggle on reload");

    a_capture_val: assert property (@(posedge clock) disable iff (rst)
        capt_evt |=> capt_ff == $past(count_ff))
        else $error("capture value wrong");

    a_hold_keep: assert property (@(posedge clock) disable iff (rst)
        !(rd && enabled && paddr == tca_pkg::ADDR_COUNT_HI) |=> $stable(hold_ff))
        else $error("hold changed without upper read");

    // bus answer: one wait state, one-cycle ready, error only for holes in the map
    a_ready_answer: assert property (@(posedge clock) disable iff (rst)
        take |=> pready_ff)
        else $error("access not answered next cycle");

    a_ready_pulse: assert property (@(posedge clock) disable iff (rst)
        pready_ff |=> !pready_ff)
        else $error("ready stood longer than one cycle");

    a_unmapped_err: assert property (@(posedge clock) disable iff (rst)
        take && !mapped |=> pslverr_ff)
        else $error("unmapped access gave no error");

    // nothing but a byte write may move a stopped counter
    a_idle_hold: assert property (@(posedge clock) disable iff (rst)
        !enabled && !wr |=> $stable(count_ff))
        else $error("disabled counter moved");

    a_out_quiet: assert property (@(posedge clock) disable iff (rst)
        !reload_evt |=> $stable(tout_ff))
        else $error("output moved without a reload");

    // an event in the clearing cycle must survive the clear
    a_status_set: assert property (@(posedge clock) disable iff (rst)
        (|set_vec) |=> (stat_ff & $past(set_vec)) == $past(set_vec))
        else $error("status event lost");

    // the interrupt lags a mask write by one clock, so compare only while the mask stands still
    a_irq_level: assert property (@(posedge clock) disable iff (rst)
        $stable(mask_ff) |-> irq_ff == (|(stat_ff & mask_ff)))
        else $error("interrupt level wrong");

endmodule // tca_timer

// ==== tb/tca_pin_model.sv ====
// far side of the timer pins: drives the input pin, watches the output pin
module tca_pin_model (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic timer_out,
    output logic      timer_in
);
    timeunit 1ns;
    timeprecision 1ns;

    int   toggles;                                   // output changes since reset
    logic last_ff;                                   // output level at previous edge

    initial timer_in = 1'b0;                         // idle low, pin already set up before enable

    // each change of the output pin is one reload seen from outside
    always @(posedge clock) begin
        if (rst) begin
            toggles <= 0;
            last_ff <= 1'b0;
        end else if (timer_out !== last_ff) begin
            toggles <= toggles + 1;
            last_ff <= timer_out;
        end
    end

    // a pulse is a rise then a fall, each level held gap cycles
    // gap >= 2 keeps every level visible to a one-clock edge detector
    task automatic pulses(input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge clock);
            timer_in <= 1'b1;
            repeat (gap) @(posedge clock);
            timer_in <= 1'b0;
        end
    endtask
endmodule // tca_pin_model

// ==== tb/tb.sv ====
// self-checking bench for the timer count access block
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock, rst, psel, penable, pwrite;  // clock, reset, apb control
    logic [7:0]  paddr;                              // apb address
    logic [31:0] pwdata, prdata, rd;                 // write data, read data, last read
    logic        pready, pslverr, er;                // apb answer, last error
    logic        timer_in, timer_out, irq;           // pins and interrupt
    int          n_errors, compares;                 // verdict counters
    int          m, r, g;                            // random counts
    logic [15:0] c1;                                 // first captured count
    logic [7:0]  v;                                  // random byte

    tca_timer u_tca_timer (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .timer_in(timer_in), .timer_out(timer_out), .irq(irq));
    tca_pin_model u_tca_pin_model (.clock(clock), .rst(rst), .timer_out(timer_out),
        .timer_in(timer_in));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // control word from enable and mode
    function automatic logic [31:0] ctrl(input logic en, input tca_pkg::tca_mode_t md);
        return (32'(en) << tca_pkg::CTRL_EN_BIT) | (32'(md) << tca_pkg::CTRL_MODE_LO);
    endfunction

    // first qualifying edge only starts counting, so n edges give n-1
    function automatic logic [31:0] counted(input int n);
        return 32'(n - 1);
    endfunction

    task automatic give_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; an idle edge first so no signal is driven twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin                // bounded wait for ready
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            n_errors++;
            give_verdict();
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    initial begin
        void'($urandom(32'h6c78a4b8));
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        // reset values of control, upper count, reload and status, and the unmapped error
        rchk("ctrl", tca_pkg::ADDR_CTRL, 32'h0);
        rchk("hi", tca_pkg::ADDR_COUNT_HI, 32'h0);
        rchk("reload", tca_pkg::ADDR_RELOAD, 32'h0000FFFF);
        rchk("status", tca_pkg::ADDR_STATUS, 32'h0);
        rchk("unmapped", 8'h1C, 32'h0);
        chk("slverr", 32'(er), 32'h1);

        // counter mode: first edge only starts, raises nothing
        apb(1'b1, tca_pkg::ADDR_CTRL, ctrl(1'b1, tca_pkg::TCA_MODE_COUNTER));
        u_tca_pin_model.pulses(1, 3);
        // upper read first, so the lower read shows the live count through the snapshot
        rchk("start_hi", tca_pkg::ADDR_COUNT_HI, 32'h0);
        rchk("start_cnt", tca_pkg::ADDR_COUNT_LO, 32'h0);
        rchk("start_stat", tca_pkg::ADDR_STATUS, 32'h0);
        m = 2 + $urandom % 8;
        u_tca_pin_model.pulses(m, 3);
        rchk("hi_cnt", tca_pkg::ADDR_COUNT_HI, 32'h0);
        u_tca_pin_model.pulses(2, 3);
        rchk("held_lo", tca_pkg::ADDR_COUNT_LO, counted(m + 1));
        rchk("held_lo2", tca_pkg::ADDR_COUNT_LO, counted(m + 1));
        rchk("hi_cnt2", tca_pkg::ADDR_COUNT_HI, 32'h0);
        rchk("new_lo", tca_pkg::ADDR_COUNT_LO, counted(m + 3));

        // disabled: live reads, byte writes land alone
        apb(1'b1, tca_pkg::ADDR_CTRL, ctrl(1'b0, tca_pkg::TCA_MODE_COUNTER));
        u_tca_pin_model.pulses(1, 3);
        rchk("live_lo", tca_pkg::ADDR_COUNT_LO, counted(m + 3));
        v = 8'($urandom);
        apb(1'b1, tca_pkg::ADDR_COUNT_LO, 32'(v));
        rchk("wr_lo", tca_pkg::ADDR_COUNT_LO, 32'(v));
        rchk("hi_kept", tca_pkg::ADDR_COUNT_HI, 32'h0);
        apb(1'b1, tca_pkg::ADDR_COUNT_HI, 32'h000000A5);
        rchk("lo_kept", tca_pkg::ADDR_COUNT_LO, 32'(v));

        // continuous or spare mode: reloads toggle the pin and raise the interrupt
        apb(1'b1, tca_pkg::ADDR_COUNT_HI, 32'h0);
        apb(1'b1, tca_pkg::ADDR_COUNT_LO, 32'h0);
        r = 2 + $urandom % 19;
        apb(1'b1, tca_pkg::ADDR_RELOAD, 32'(r));
        apb(1'b1, tca_pkg::ADDR_MASK, 32'h1);
        apb(1'b1, tca_pkg::ADDR_CTRL, ctrl(1'b1, ($urandom % 2) ? tca_pkg::TCA_MODE_SPARE
                                                                : tca_pkg::TCA_MODE_CONT));
        repeat (3 * r + 5) @(posedge clock);
        apb(1'b1, tca_pkg::ADDR_CTRL, 32'h0);
        apb(1'b0, tca_pkg::ADDR_COUNT_LO, 32'h0);
        chk("cnt_range", 32'(rd >= 1 && rd <= r), 32'h1);
        chk("toggled", 32'(u_tca_pin_model.toggles >= 2), 32'h1);
        chk("pin_level", 32'(timer_out), 32'(u_tca_pin_model.toggles % 2));
        chk("irq_on", 32'(irq), 32'h1);
        apb(1'b1, tca_pkg::ADDR_MASK, 32'h0);
        repeat (2) @(posedge clock);
        chk("irq_masked", 32'(irq), 32'h0);
        apb(1'b1, tca_pkg::ADDR_STATUS, 32'h1);
        rchk("cleared", tca_pkg::ADDR_STATUS, 32'h0);

        // capture mode: difference of two captures is the clocks between edges
        apb(1'b1, tca_pkg::ADDR_RELOAD, 32'h0000FFFF);
        apb(1'b1, tca_pkg::ADDR_CTRL, ctrl(1'b1, tca_pkg::TCA_MODE_CAPTURE));
        g = 20 + $urandom % 10;
        fork
            u_tca_pin_model.pulses(2, g);
            begin
                repeat (g + g / 2) @(posedge clock);
                apb(1'b0, tca_pkg::ADDR_CAPTURE, 32'h0);
                c1 = rd[15:0];
            end
        join
        repeat (4) @(posedge clock);
        apb(1'b0, tca_pkg::ADDR_CAPTURE, 32'h0);
        chk("capt_gap", 32'(rd[15:0] - c1), 32'(2 * g));
        rchk("capt_stat", tca_pkg::ADDR_STATUS, 32'h2);
        give_verdict();
    end
endmodule // tb
